// file: verilog/bcs_pkg.sv
// Shared types and constants for the bus cycle sequencer
package bcs_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int STAT_W = 3;
    // Status codes, ordered {space select, status1, status0}
    localparam logic [2:0] ST_CODE_FETCH = 3'h3;
    localparam logic [2:0] ST_CODE_MEM_RD = 3'h2;
    localparam logic [2:0] ST_CODE_MEM_WR = 3'h1;
    localparam logic [2:0] ST_CODE_PORT_RD = 3'h6;
    localparam logic [2:0] ST_CODE_PORT_WR = 3'h5;
    localparam logic [2:0] ST_CODE_ACK = 3'h7;
    localparam logic [2:0] ST_CODE_IDLE_DAD = 3'h2;
    localparam logic [2:0] ST_CODE_IDLE_RST = 3'h7;
    localparam logic [1:0] ST_EXT = 2'h3;
    localparam logic [1:0] ST_PARKED = 2'h0;

    typedef enum logic [2:0] {
        opcode_fetch_cycle, memory_read_cycle, memory_write_cycle,
        port_read_cycle, port_write_cycle, irq_ack_cycle,
        bus_idle_cycle, bus_idle_rst_cycle
    } bcs_kind_t;

    typedef enum logic [3:0] {
        S_T1, S_T2, S_WAIT, S_T3, S_T4, S_T5, S_T6,
        S_RESET, S_HALT, S_HOLD
    } bcs_state_t;

    typedef struct packed {
        bcs_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic long_fetch;   // Six-state fetch instead of four
        logic no_ale;       // Second or third cycle of double_add_instruction
    } bcs_req_t;

    localparam bcs_req_t REQ_RESET = '{bus_idle_cycle, 16'h0000, 8'h00, 1'b0, 1'b0};
endpackage : bcs_pkg

// file: verilog/bcs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bcs_sync #(
    parameter int W = 1
) (
    input wire logic core_clk_in,   // Core clock
    input wire logic rst_in,        // Async reset, active high
    input wire logic [W-1:0] d_in,  // Asynchronous level
    output logic [W-1:0] q_out      // Synchronised level
);
    logic [W-1:0] meta_q;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule : bcs_sync
`default_nettype wire

// file: verilog/bcs_sequencer.sv
// Bus cycle sequencer: T-state machine driving the multiplexed bus pins
`timescale 1ns/1ps
`default_nettype none
module bcs_sequencer
    import bcs_pkg::*;
(
    input wire logic core_clk_in,              // 10 MHz core clock
    input wire logic rst_in,                   // Async reset, active high
    input wire bcs_req_t req_in,               // Machine cycle request
    input wire logic req_valid_in,             // Request pending
    input wire logic ready_in,                 // Ready pin, async
    input wire logic hold_in,                  // Hold request pin, async
    input wire logic [DATA_W-1:0] ad_in,       // Low address/data pins, read side
    output logic req_taken_out,                // Pulse: request accepted
    output logic done_out,                     // Pulse: machine cycle ended
    output logic [DATA_W-1:0] rdata_out,       // Data captured in read cycles
    output logic [DATA_W-1:0] ad_out,          // Low address/data drive
    output logic ad_oe_out,                    // Low address/data enable
    output logic [DATA_W-1:0] addr_hi_out,     // Upper address drive
    output logic addr_hi_oe_out,               // Upper address enable
    output logic space_select_out,             // High for port space
    output logic space_select_oe_out,          // Space select enable
    output logic cycle_status1,                // Status line 1
    output logic cycle_status0,                // Status line 0
    output logic read_strobe_n_out,            // Read strobe, active low
    output logic write_strobe_n_out,           // Write strobe, active low
    output logic rw_oe_out,                    // Read/write strobe enable
    output logic irq_ack_strobe_n,             // Acknowledge strobe, active low
    output logic addr_latch_strobe_out,        // Address latch strobe
    output logic hold_ack_out                  // High while bus released for hold
);
    bcs_state_t state_q, state_d;
    bcs_req_t cur_q;
    logic ready_s, hold_s;
    logic [DATA_W-1:0] ad_s;
    logic capture_q;

    // ready may come from an outside wait-state flop, so sync it
    bcs_sync #(.W(1)) u_sync_rdy (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .d_in(ready_in), .q_out(ready_s));
    bcs_sync #(.W(1)) u_sync_hold (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .d_in(hold_in), .q_out(hold_s));
    bcs_sync #(.W(DATA_W)) u_sync_ad (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .d_in(ad_in), .q_out(ad_s));

    function automatic logic [2:0] status_of(input bcs_kind_t k);
        case (k)
            opcode_fetch_cycle: status_of = ST_CODE_FETCH;
            memory_read_cycle: status_of = ST_CODE_MEM_RD;
            memory_write_cycle: status_of = ST_CODE_MEM_WR;
            port_read_cycle: status_of = ST_CODE_PORT_RD;
            port_write_cycle: status_of = ST_CODE_PORT_WR;
            irq_ack_cycle: status_of = ST_CODE_ACK;
            bus_idle_cycle: status_of = ST_CODE_IDLE_DAD;
            default: status_of = ST_CODE_IDLE_RST;
        endcase
    endfunction : status_of

    function automatic logic is_rd(input bcs_kind_t k);
        is_rd = (k == opcode_fetch_cycle) || (k == memory_read_cycle) ||
                (k == port_read_cycle);
    endfunction : is_rd

    function automatic logic is_wr(input bcs_kind_t k);
        is_wr = (k == memory_write_cycle) || (k == port_write_cycle);
    endfunction : is_wr

    function automatic logic is_port(input bcs_kind_t k);
        is_port = (k == port_read_cycle) || (k == port_write_cycle);
    endfunction : is_port

    // Cycle boundary: a request or hold is only looked at here
    wire logic cur_fetch = (cur_q.kind == opcode_fetch_cycle);
    wire logic xfer_end = (state_q == S_T3 && !cur_fetch) ||
                          (state_q == S_T4 && !cur_q.long_fetch) || (state_q == S_T6);
    wire logic parked = (state_q == S_RESET) || (state_q == S_HALT) ||
                        (state_q == S_HOLD);
    wire logic boundary = xfer_end || parked;
    // hold beats a new request, taken only once the cycle is over
    wire logic take = boundary && !hold_s && req_valid_in;

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_T1: state_d = S_T2;
            S_T2: state_d = ready_s ? S_T3 : S_WAIT;
            S_WAIT: state_d = ready_s ? S_T3 : S_WAIT;
            S_T3: state_d = cur_fetch ? S_T4 : S_HALT;
            S_T4: state_d = cur_q.long_fetch ? S_T5 : S_HALT;
            S_T5: state_d = S_T6;
            default: state_d = S_HALT;
        endcase
        // Idle time with no request parks the bus as in halt
        if (boundary) begin
            state_d = hold_s ? S_HOLD : (req_valid_in ? S_T1 : S_HALT);
        end
    end

    wire bcs_req_t cur_d = take ? req_in : cur_q;
    wire bcs_kind_t kd = cur_d.kind;
    wire logic [2:0] code_d = status_of(kd);
    wire logic ph_t1 = (state_d == S_T1);
    wire logic ph_xfer = (state_d == S_T2) || (state_d == S_WAIT) || (state_d == S_T3);
    wire logic ph_ext = (state_d == S_T4) || (state_d == S_T5) || (state_d == S_T6);
    wire logic ph_float = (state_d == S_RESET) || (state_d == S_HALT) ||
                          (state_d == S_HOLD);

    // status from T1, zero when parked
    // extended fetch states show status 11
    wire logic [1:0] status_d = ph_float ? ST_PARKED : (ph_ext ? ST_EXT : code_d[1:0]);
    wire logic sel_d = ph_ext ? (kd == irq_ack_cycle) : code_d[2];
    // port address mirrored on the upper lines
    wire logic [DATA_W-1:0] hi_d = is_port(kd) ? cur_d.addr[DATA_W-1:0] :
                                   cur_d.addr[ADDR_W-1:DATA_W];
    wire logic [DATA_W-1:0] ad_d = ph_t1 ? cur_d.addr[DATA_W-1:0] : cur_d.wdata;
    // bus floated when parked; data floated in T4-T6
    wire logic ad_oe_d = ph_t1 || (ph_xfer && is_wr(kd));
    // latch strobe in T1 unless double-add follow-on
    wire logic ale_d = ph_t1 && !cur_d.no_ale;
    // strobes only in the transfer phase
    wire logic rd_n_d = !(ph_xfer && is_rd(kd));
    wire logic wr_n_d = !(ph_xfer && is_wr(kd));
    wire logic ack_n_d = !(ph_xfer && kd == irq_ack_cycle);
    // Synced data pins lag two edges, so the byte is taken one edge after T3
    wire logic capture = (state_q == S_T3) && (is_rd(cur_q.kind) ||
                         cur_q.kind == irq_ack_cycle);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= S_RESET;
            cur_q <= REQ_RESET;
            rdata_out <= '0;
            req_taken_out <= 1'b0;
            done_out <= 1'b0;
            capture_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            req_taken_out <= take;
            done_out <= xfer_end;
            capture_q <= capture;
            if (capture_q) begin
                rdata_out <= ad_s;
            end
        end
    end

    // pins in reset state show floated bus, strobes idle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            {cycle_status1, cycle_status0} <= ST_PARKED;
            space_select_out <= 1'b0;
            space_select_oe_out <= 1'b0;
            addr_hi_out <= '0;
            addr_hi_oe_out <= 1'b0;
            ad_out <= '0;
            ad_oe_out <= 1'b0;
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            rw_oe_out <= 1'b0;
            irq_ack_strobe_n <= 1'b1;
            addr_latch_strobe_out <= 1'b0;
            hold_ack_out <= 1'b0;
        end else begin
            {cycle_status1, cycle_status0} <= status_d;
            space_select_out <= sel_d;
            space_select_oe_out <= !ph_float;
            addr_hi_out <= hi_d;
            addr_hi_oe_out <= !ph_float;
            ad_out <= ad_d;
            ad_oe_out <= ad_oe_d;
            read_strobe_n_out <= rd_n_d;
            write_strobe_n_out <= wr_n_d;
            rw_oe_out <= !ph_float;
            irq_ack_strobe_n <= ack_n_d;
            addr_latch_strobe_out <= ale_d;
            hold_ack_out <= (state_d == S_HOLD);
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // Pin values lag the state register by nothing: both load from the same _d
    a_latch_t1_only: assert property (addr_latch_strobe_out |-> state_q == S_T1 && !cur_q.no_ale)
        else $error("latch strobe outside T1");
    a_no_latch_dad: assert property (state_q == S_T1 && cur_q.no_ale |-> !addr_latch_strobe_out)
        else $error("latch strobe in double add follow-on");
    a_fetch_strobes: assert property (state_q == S_T2 && cur_fetch |-> !read_strobe_n_out && write_strobe_n_out && irq_ack_strobe_n && {space_select_out, cycle_status1, cycle_status0} == ST_CODE_FETCH)
        else $error("fetch strobes or status wrong");
    a_write_strobes: assert property (state_q == S_T2 && is_wr(cur_q.kind) |-> !write_strobe_n_out && read_strobe_n_out && ad_oe_out && ad_out == cur_q.wdata)
        else $error("write strobes wrong");
    a_ack_strobe: assert property (state_q == S_T3 && cur_q.kind == irq_ack_cycle |-> !irq_ack_strobe_n && read_strobe_n_out && {cycle_status1, cycle_status0} == ST_EXT)
        else $error("ack cycle wrong");
    a_wait_stretch: assert property (state_q == S_WAIT && !ready_s |=> state_q == S_WAIT && $stable(read_strobe_n_out) && $stable(write_strobe_n_out))
        else $error("wait state not held");
    a_three_states: assert property ((state_q == S_T1 && !cur_fetch) ##1 (state_q == S_T2 && ready_s) |=> state_q == S_T3 ##1 (state_q == S_T1 || parked))
        else $error("non fetch cycle length wrong");
    a_fetch_four: assert property (state_q == S_T3 && cur_fetch && !cur_q.long_fetch |=> state_q == S_T4 ##1 state_q != S_T5)
        else $error("fetch length wrong");
    a_ext_states: assert property (state_q inside {S_T4, S_T5, S_T6} |-> cycle_status1 && cycle_status0 && !ad_oe_out && read_strobe_n_out && write_strobe_n_out && space_select_out == (cur_q.kind == irq_ack_cycle))
        else $error("extended state pins wrong");
    a_port_mirror: assert property (state_q == S_T1 && is_port(cur_q.kind) |-> addr_hi_out == ad_out)
        else $error("port address not mirrored");
    a_hold_float: assert property (xfer_end && hold_s |=> state_q == S_HOLD && hold_ack_out && !ad_oe_out && !addr_hi_oe_out && !rw_oe_out && !space_select_oe_out)
        else $error("hold not honoured");
    a_parked_pins: assert property (parked |-> !addr_latch_strobe_out && irq_ack_strobe_n && !rw_oe_out && !ad_oe_out)
        else $error("parked pins wrong");
    a_status_t1: assert property (state_q == S_T1 |-> {space_select_out, cycle_status1, cycle_status0} == status_of(cur_q.kind) && read_strobe_n_out && write_strobe_n_out)
        else $error("status not valid in T1");

    c_wait: cover property (state_q == S_WAIT ##1 state_q == S_T3);
    c_hold: cover property (state_q == S_HOLD ##1 state_q == S_T1);
    c_long_fetch: cover property (state_q == S_T6);
    c_port_write: cover property (state_q == S_T3 && cur_q.kind == port_write_cycle);
endmodule : bcs_sequencer
`default_nettype wire

// file: dv/bcs_bus_dev.sv
// Memory and port device model on the far side of the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module bcs_bus_dev
    import bcs_pkg::*;
(
    input wire logic core_clk_in,            // Core clock
    input wire logic slow_in,                // Stretch transfers with ready low
    input wire logic [DATA_W-1:0] ad_drv_in, // Sequencer low bus drive
    input wire logic ad_oe_in,               // Sequencer low bus enable
    input wire logic [DATA_W-1:0] hi_in,     // Upper address lines
    input wire logic sel_in,                 // Space select line
    input wire logic rd_n_in,                // Read strobe
    input wire logic wr_n_in,                // Write strobe
    input wire logic ack_n_in,               // Acknowledge strobe
    input wire logic ale_in,                 // Address latch strobe
    output logic [DATA_W-1:0] ad_out,        // Wire level of the low bus
    output logic ready_out,                  // Ready pin
    output logic [DATA_W-1:0] wdata_out      // Last byte written
);
    logic [7:0] lo_q = 8'h00, hi_q = 8'h00, last_q = 8'h00, dat;
    logic sel_q = 1'b0;
    logic [1:0] cnt_q = 2'h3;
    logic drive, strb;
    // top page of memory space reads with pattern c3 instead of 5a
    assign dat = lo_q ^ hi_q ^ ((!sel_q && hi_q == 8'hff) ? 8'hc3 : 8'h5a);
    assign drive = !rd_n_in || !ack_n_in;
    // No pull-up, so a released bus shows the inverse of its last level
    assign ad_out = ad_oe_in ? ad_drv_in : (drive ? dat : ~last_q);
    assign strb = !rd_n_in || !wr_n_in || !ack_n_in;
    // slow device holds ready low, one-clock pulse mid transfer
    // Ready is seen two edges late, so it must already be low before T1
    assign ready_out = !slow_in || (strb && cnt_q == 2'h1);
    always @(posedge core_clk_in) begin
        last_q <= ad_out;
        // latch low address on the strobe
        if (ale_in) begin
            lo_q <= ad_out;
            hi_q <= hi_in;
            sel_q <= sel_in;
            cnt_q <= 2'h0;
        end else if (!rd_n_in || !wr_n_in || !ack_n_in) begin
            cnt_q <= (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
        end
        if (!wr_n_in) begin
            wdata_out <= ad_out;
        end
    end
endmodule : bcs_bus_dev
`default_nettype wire

// file: dv/bcs_sequencer_tb.sv
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module bcs_sequencer_tb
    import bcs_pkg::*;
;
    typedef struct {bcs_req_t r; logic slow;} bcs_exp_t;
    logic clk = 1'b0, rst = 1'b1, valid = 1'b0, hold = 1'b0, slow = 1'b0;
    bcs_req_t req = REQ_RESET;
    logic taken, done, ad_oe, hi_oe, sel, sel_oe, s1, s0, rd_n, wr_n, rw_oe, ack_n, ale, hack;
    logic ready, act = 1'b0, rpend = 1'b0;
    logic [7:0] rdata, ad_o, hi, ad_w, wdat, rexp;
    logic [2:0] codes[8] = '{3'h3, 3'h2, 3'h1, 3'h6, 3'h5, 3'h7, 3'h2, 3'h7};
    logic [2:0] stb[8] = '{3'h4, 3'h4, 3'h2, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
    int err_total = 0, checks = 0, cyc = 0, n, rdl, wrl, akl, post, sl;
    logic [31:0] lfsr = 32'ha39a;
    bcs_exp_t q[$], e;
    logic prt;

    bcs_sequencer uut (.core_clk_in(clk), .rst_in(rst), .req_in(req), .req_valid_in(valid),
        .ready_in(ready), .hold_in(hold), .ad_in(ad_w), .req_taken_out(taken),
        .done_out(done), .rdata_out(rdata), .ad_out(ad_o), .ad_oe_out(ad_oe),
        .addr_hi_out(hi), .addr_hi_oe_out(hi_oe), .space_select_out(sel),
        .space_select_oe_out(sel_oe), .cycle_status1(s1), .cycle_status0(s0),
        .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n), .rw_oe_out(rw_oe),
        .irq_ack_strobe_n(ack_n), .addr_latch_strobe_out(ale), .hold_ack_out(hack));
    bcs_bus_dev dev (.core_clk_in(clk), .slow_in(slow), .ad_drv_in(ad_o), .ad_oe_in(ad_oe),
        .hi_in(hi), .sel_in(sel), .rd_n_in(rd_n), .wr_n_in(wr_n), .ack_n_in(ack_n),
        .ale_in(ale), .ad_out(ad_w), .ready_out(ready), .wdata_out(wdat));

    always #50 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt

    function automatic logic [7:0] rd_exp(bcs_req_t r);
        logic [7:0] h;
        h = prt ? r.addr[7:0] : r.addr[15:8];
        return r.addr[7:0] ^ h ^ ((codes[r.kind][2] == 1'b0 && h == 8'hff) ? 8'hc3 : 8'h5a);
    endfunction : rd_exp

    task automatic issue(bcs_kind_t k, logic lf, logic na);
        int i;
        i = 0;
        lfsr = nxt(lfsr);
        req = '{k, lfsr[15:0], lfsr[23:16], lf, na};
        if (lfsr[24]) req.addr[15:8] = 8'hff;
        valid = 1'b1;
        q.push_back('{req, slow});
        do begin
            @(posedge clk) #1;
            i++;
        end while (taken !== 1'b1 && i < 50);
        chk("taken", taken, 1'b1);
    endtask : issue

    task automatic park(string w, logic hk);
        // latch strobe low, ack high, bus floated
        chk(w, {ale, ack_n, sel_oe, rw_oe, ad_oe, hi_oe, hack}, {2'b01, 4'h0, hk});
    endtask : park

    task automatic fin();
        prt = e.r.kind inside {port_read_cycle, port_write_cycle};
        sl = rdl + wrl + akl;
        chk("strobe kind", {rdl != 0, wrl != 0, akl != 0}, stb[e.r.kind]);
        chk("length", 16'(n), 16'(sl == 0 ? 3 : sl + 1 + post));
        chk("tail", 16'(post), e.r.kind != opcode_fetch_cycle ? 0 : (e.r.long_fetch ? 3 : 1));
        if (sl != 0 && !e.slow) chk("strobe len", 16'(sl), 16'd2);
        if (sl != 0 && e.slow) chk("stretch", sl > 2, 1'b1);
        if (stb[e.r.kind] != 3'h2 && sl != 0) begin
            rexp = rd_exp(e.r);
            rpend = 1'b1;
        end
        if (stb[e.r.kind] == 3'h2) chk("wdata", wdat, e.r.wdata);
    endtask : fin

    always @(negedge clk) begin
        if (!rst) begin
            // Read byte lands at most one edge after the cycle ends
            if (rpend) chk("rdata", rdata, rexp);
            rpend = 1'b0;
            if (done === 1'b1 && act) fin();
            if (done === 1'b1) act = 1'b0;
            if (taken === 1'b1) begin
                e = q.pop_front();
                prt = e.r.kind inside {port_read_cycle, port_write_cycle};
                {act, n, rdl, wrl, akl, post} = {1'b1, 32'd1, 128'd0};
                chk("status", {sel_oe, sel, s1, s0}, {1'b1, codes[e.r.kind]});
                chk("latch strobe", ale, !e.r.no_ale);
                chk("ad t1", {ad_oe, ad_o}, {1'b1, e.r.addr[7:0]});
                chk("hi", {hi_oe, hi}, {1'b1, prt ? e.r.addr[7:0] : e.r.addr[15:8]});
                chk("t1 strobes", {rd_n, wr_n, ack_n}, 3'h7);
            end else if (act) begin
                n++;
                rdl += (rd_n === 1'b0);
                wrl += (wr_n === 1'b0);
                akl += (ack_n === 1'b0);
                if ({rd_n, wr_n, ack_n} === 3'h7 && rdl + wrl + akl > 0) begin
                    post++;
                    chk("t4 pins", {s1, s0, ad_oe, sel}, 4'hc);
                end else begin
                    chk("status held", {sel, s1, s0}, codes[e.r.kind]);
                end
            end
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 park("reset", 1'b0);
        rst = 1'b0;
        @(posedge clk) #1;
        for (int i = 0; i < 8; i++) issue(bcs_kind_t'(i), 1'b0, 1'b0);
        issue(opcode_fetch_cycle, 1'b1, 1'b0);
        issue(bus_idle_cycle, 1'b0, 1'b1);
        valid = 1'b0;
        repeat (10) @(posedge clk) #1;
        park("halt", 1'b0);
        chk("halt status", {s1, s0}, 2'h0);
        $display("test kinds done");
        slow = 1'b1;
        for (int i = 0; i < 12; i++) issue(bcs_kind_t'(3'(lfsr[27:25] % 6)), lfsr[28], 1'b0);
        valid = 1'b0;
        repeat (12) @(posedge clk) #1;
        slow = 1'b0;
        $display("test waits done");
        issue(memory_read_cycle, 1'b0, 1'b0);
        hold = 1'b1;
        fork
            issue(port_write_cycle, 1'b0, 1'b0);
            begin
                for (int i = 0; i < 20 && hack !== 1'b1; i++) @(posedge clk) #1;
                repeat (5) begin
                    park("hold", 1'b1);
                    chk("no take", taken, 1'b0);
                    @(posedge clk) #1;
                end
                hold = 1'b0;
            end
        join
        valid = 1'b0;
        repeat (10) @(posedge clk) #1;
        chk("queue", 16'(q.size()), 16'd0);
        $display("test hold done");
        end_sim();
    end
endmodule : bcs_sequencer_tb
`default_nettype wire
